// File: src/ras_record_window_and_syndrome.sv
module ras_record_window_and_syndrome (
  // clock and reset
  input  wire logic                              CLOCK,
  input  wire logic                              RST_B,
  // system-register access port
  input  wire logic [1:0]                        SR_OP0,
  input  wire logic [2:0]                        SR_OP1,
  input  wire logic [3:0]                        SR_CRN,
  input  wire logic [3:0]                        SR_CRM,
  input  wire logic [2:0]                        SR_OP2,
  input  wire logic [ras_window_pkg::DATA_W-1:0] SR_WDATA,
  input  wire logic                              SR_WR,
  input  wire logic                              SR_RD,
  output logic      [ras_window_pkg::DATA_W-1:0] SR_RDATA,
  output logic                                   SR_UNDEF,
  output logic                                   SR_TRAP_EL2,
  output logic                                   SR_TRAP_EL3,
  // execution context
  input  wire logic [1:0]                        CUR_EL,
  input  wire logic                              TRUST_WORLD_BIT,
  input  wire logic                              GENERAL_EXCEPTION_TRAP,
  input  wire logic                              HOST_EL2_MODE,
  input  wire logic                              HYP_ERROR_REGISTER_TRAP,
  input  wire logic                              MON_ERROR_REGISTER_TRAP,
  input  wire logic [ras_window_pkg::DATA_W-1:0] AUX_CONTROL_EL2,
  input  wire logic [ras_window_pkg::DATA_W-1:0] AUX_CONTROL_EL3,
  // core log port
  output logic                                   CORE_CTL_WR,
  output logic                                   CORE_CTL_RD,
  output logic                                   CORE_FEAT_RD,
  output logic                                   CORE_STAT_RD,
  input  wire logic [ras_window_pkg::DATA_W-1:0] CORE_CTL_RDATA,
  input  wire logic [ras_window_pkg::DATA_W-1:0] CORE_FEAT_RDATA,
  input  wire logic [ras_window_pkg::DATA_W-1:0] CORE_STAT_RDATA,
  // cluster log port
  output logic                                   CLUSTER_CTL_WR,
  output logic                                   CLUSTER_CTL_RD,
  output logic                                   CLUSTER_FEAT_RD,
  output logic                                   CLUSTER_STAT_RD,
  input  wire logic [ras_window_pkg::DATA_W-1:0] CLUSTER_CTL_RDATA,
  input  wire logic [ras_window_pkg::DATA_W-1:0] CLUSTER_FEAT_RDATA,
  input  wire logic [ras_window_pkg::DATA_W-1:0] CLUSTER_STAT_RDATA,
  // shared write data to the logs
  output logic      [ras_window_pkg::DATA_W-1:0] LOG_WDATA,
  // exception capture
  input  wire logic                              EXC_TAKE_EL1,
  input  wire logic [5:0]                        EXC_CLASS,
  input  wire logic                              EXC_INSN_32,
  input  wire logic                              EXC_SYND_VALID,
  input  wire logic [23:0]                       EXC_SYND,
  input  wire logic [23:0]                       EXC_SERROR_SYND,
  output logic      [ras_window_pkg::DATA_W-1:0] EL1_SYNDROME
);
  import ras_window_pkg::*;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  // ==========================================================
  // decode
  // ==========================================================
  wire logic base_hit  = (SR_OP0 == SYSREG_OP0) && (SR_OP1 == SYSREG_OP1)
                       && (SR_CRN == SYSREG_CRN);
  wire logic hit_ctl   = base_hit && (SR_CRM == SYSREG_CRM_INJ)
                       && (SR_OP2 == SYSREG_OP2_CTL);
  wire logic hit_feat  = base_hit && (SR_CRM == SYSREG_CRM_INJ)
                       && (SR_OP2 == SYSREG_OP2_FEAT);
  wire logic hit_sel   = base_hit && (SR_CRM == SYSREG_CRM_OWN) && (SR_OP2 == SYSREG_OP2_SEL);
  wire logic hit_stat  = base_hit && (SR_CRM == SYSREG_CRM_OWN) && (SR_OP2 == SYSREG_OP2_STAT);
  wire logic hit_synd  = base_hit && (SR_CRM == SYSREG_CRM_OWN) && (SR_OP2 == SYSREG_OP2_SYND);
  wire logic hit_inj   = hit_ctl || hit_feat;
  wire logic any_acc   = SR_WR || SR_RD;

  // ==========================================================
  // permission and trap routing
  // ==========================================================
  wire logic at_el0    = (CUR_EL == 2'h0);
  wire logic at_el1    = (CUR_EL == 2'h1);
  wire logic at_el2    = (CUR_EL == 2'h2);
  // EL2 in secure world and EL1 under a live host trap cannot execute
  wire logic tge_live  = GENERAL_EXCEPTION_TRAP && TRUST_WORLD_BIT;
  wire logic na_level  = (at_el2 && !TRUST_WORLD_BIT) || (at_el1 && tge_live);
  wire logic reach_el1 = AUX_CONTROL_EL2[AUX_ENABLE_BIT] && AUX_CONTROL_EL3[AUX_ENABLE_BIT];
  wire logic reach_el2 = AUX_CONTROL_EL3[AUX_ENABLE_BIT];
  wire logic reachable = (CUR_EL == 2'h3) || (at_el1 && reach_el1)
                       || (at_el2 && reach_el2);
  wire logic feat_wr   = hit_feat && SR_WR;
  wire logic undef_inj = hit_inj && (at_el0 || na_level || !reachable || feat_wr);
  wire logic undef_oth = (hit_sel || hit_stat || hit_synd) && (at_el0 || na_level);
  wire logic unmapped  = !(hit_inj || hit_sel || hit_stat || hit_synd);
  wire logic undef_any = any_acc && (undef_inj || undef_oth || unmapped);
  wire logic trap3     = any_acc && hit_inj && !undef_any && MON_ERROR_REGISTER_TRAP
                       && (at_el1 || at_el2);
  wire logic trap2     = any_acc && hit_inj && !undef_any && !trap3 && at_el1
                       && TRUST_WORLD_BIT && HYP_ERROR_REGISTER_TRAP;
  wire logic granted   = any_acc && !undef_any && !trap2 && !trap3;
  access_outcome_t outcome;
  assign outcome = undef_any ? ACC_UNDEF : trap3 ? ACC_TRAP_EL3 :
                   trap2 ? ACC_TRAP_EL2 : ACC_OK;
  assign SR_UNDEF    = (outcome == ACC_UNDEF);
  assign SR_TRAP_EL3 = (outcome == ACC_TRAP_EL3);
  assign SR_TRAP_EL2 = (outcome == ACC_TRAP_EL2);

  // ==========================================================
  // chooser and forwarding
  // ==========================================================
  logic chooser_reg;
  logic chooser_next;
  assign chooser_next = (granted && SR_WR && hit_sel) ? SR_WDATA[CHOOSER_BIT] : chooser_reg;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      chooser_reg <= CHOOSER_RESET;
    end else begin
      chooser_reg <= chooser_next;
    end
  end

  wire logic fwd_ok = granted && hit_ctl;
  assign CORE_CTL_WR     = fwd_ok && SR_WR && !chooser_reg;
  assign CORE_CTL_RD     = fwd_ok && SR_RD && !chooser_reg;
  assign CLUSTER_CTL_WR  = fwd_ok && SR_WR && chooser_reg;
  assign CLUSTER_CTL_RD  = fwd_ok && SR_RD && chooser_reg;
  assign CORE_FEAT_RD    = granted && hit_feat && SR_RD && !chooser_reg;
  assign CLUSTER_FEAT_RD = granted && hit_feat && SR_RD && chooser_reg;
  assign CORE_STAT_RD    = granted && hit_stat && SR_RD && !chooser_reg;
  assign CLUSTER_STAT_RD = granted && hit_stat && SR_RD && chooser_reg;
  // status writes reach no log; only the control-write strobes take LOG_WDATA to the chosen log
  assign LOG_WDATA       = SR_WDATA;

  // ==========================================================
  // syndrome capture
  // ==========================================================
  // classes that never carry a trapped opcode size, plus data aborts without a valid syndrome
  wire logic size_forced = (EXC_CLASS == EC_SERROR) || (EXC_CLASS == EC_UNKNOWN)
                         || (EXC_CLASS == EC_INSN_ABORT_L) || (EXC_CLASS == EC_INSN_ABORT_S)
                         || (EXC_CLASS == EC_PC_ALIGN) || (EXC_CLASS == EC_SP_ALIGN)
                         || (EXC_CLASS == EC_ILLEGAL)
                         || (((EXC_CLASS == EC_DATA_ABORT_L) || (EXC_CLASS == EC_DATA_ABORT_S))
                             && !EXC_SYND_VALID);
  wire logic        cap_size  = size_forced || EXC_INSN_32;
  wire logic        is_serror = (EXC_CLASS == EC_SERROR);
  wire logic        cap_valid = EXC_SYND_VALID || is_serror;
  wire logic [23:0] cap_field = !cap_valid ? 24'h00_0000 :
                                is_serror ? EXC_SERROR_SYND : EXC_SYND;
  wire logic [31:0] cap_word  = {EXC_CLASS, cap_size, cap_valid, cap_field};
  // software writes keep the invalid-means-zero shape
  wire logic [31:0] sw_word   = {SR_WDATA[31:SYND_VALID_BIT],
                                 SR_WDATA[SYND_VALID_BIT] ? SR_WDATA[23:0] : 24'h00_0000};

  logic [31:0] synd_reg;
  logic [31:0] synd_next;
  // an exception in the same cycle as a software write wins
  assign synd_next = EXC_TAKE_EL1 ? cap_word :
                     (granted && SR_WR && hit_synd) ? sw_word : synd_reg;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      synd_reg <= SYND_RESET;
    end else begin
      synd_reg <= synd_next;
    end
  end
  assign EL1_SYNDROME = synd_reg;

  // ==========================================================
  // read data, one cycle after the strobe
  // ==========================================================
  wire logic [31:0] ctl_sel  = chooser_reg ? CLUSTER_CTL_RDATA : CORE_CTL_RDATA;
  wire logic [31:0] feat_sel = chooser_reg ? CLUSTER_FEAT_RDATA : CORE_FEAT_RDATA;
  wire logic [31:0] stat_sel = chooser_reg ? CLUSTER_STAT_RDATA : CORE_STAT_RDATA;
  wire logic [31:0] rd_mux   = !(granted && SR_RD) ? 32'h0000_0000 :
                               hit_ctl ? ctl_sel : hit_feat ? feat_sel :
                               hit_stat ? stat_sel : hit_synd ? synd_reg :
                               {31'h0000_0000, chooser_reg};

  logic [31:0] rdata_reg;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rd_mux;
    end
  end
  assign SR_RDATA = rdata_reg;

  // ==========================================================
  // checks
  // ==========================================================
  a_el0_undef: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (any_acc && hit_ctl && at_el0) |-> (SR_UNDEF && !CORE_CTL_WR && !CLUSTER_CTL_WR))
    else $error("el0 control window access not undefined");
  a_core_route: assert property (@(posedge CLOCK) disable iff (!RST_B)
    CORE_CTL_WR |-> (!chooser_reg && SR_WR && !CLUSTER_CTL_WR))
    else $error("core control write with wrong chooser");
  a_cluster_route: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (granted && hit_ctl && SR_RD && chooser_reg) |-> (CLUSTER_CTL_RD && !CORE_CTL_RD))
    else $error("cluster control read not forwarded");
  a_feat_readonly: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (SR_WR && hit_feat) |-> SR_UNDEF)
    else $error("feature window write accepted");
  a_el3_reach: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (any_acc && hit_ctl && CUR_EL == 2'h3) |-> !SR_UNDEF && !SR_TRAP_EL2 && !SR_TRAP_EL3)
    else $error("el3 refused control window");
  a_trap_el3: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (any_acc && hit_inj && at_el2 && TRUST_WORLD_BIT && reach_el2 && MON_ERROR_REGISTER_TRAP)
    |-> SR_TRAP_EL3)
    else $error("missing trap to el3");
  a_trap_el2: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (any_acc && hit_inj && at_el1 && reach_el1 && TRUST_WORLD_BIT && !tge_live
     && HYP_ERROR_REGISTER_TRAP && !MON_ERROR_REGISTER_TRAP) |-> SR_TRAP_EL2)
    else $error("missing trap to el2");
  a_synd_capture: assert property (@(posedge CLOCK) disable iff (!RST_B)
    EXC_TAKE_EL1 |=> (EL1_SYNDROME[31:SYND_CLASS_LSB] == $past(EXC_CLASS)))
    else $error("syndrome class not captured");
  a_synd_zero: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !EL1_SYNDROME[SYND_VALID_BIT] |-> (EL1_SYNDROME[23:0] == 24'h00_0000))
    else $error("invalid syndrome field not zero");
  a_size_forced: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (EXC_TAKE_EL1 && EXC_CLASS == EC_UNKNOWN) |=> EL1_SYNDROME[SYND_SIZE_BIT])
    else $error("opcode size not forced");
  a_read_data: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (SR_RD && granted && hit_sel) |=> (SR_RDATA == {31'h0000_0000, $past(chooser_reg)}))
    else $error("chooser read wrong");

  a_core_ctl_rd: assert property (
    CORE_CTL_RD |-> (!chooser_reg && SR_RD && hit_ctl))
    else $error("core control read with wrong chooser");

  a_cluster_wr: assert property (
    CLUSTER_CTL_WR |-> (chooser_reg && SR_WR && hit_ctl))
    else $error("cluster control write with wrong chooser");

  a_wdata_pass: assert property (
    (CORE_CTL_WR || CLUSTER_CTL_WR) |-> (LOG_WDATA == SR_WDATA))
    else $error("log write data differs");

  a_ctl_decode: assert property (
    (CORE_CTL_WR || CLUSTER_CTL_WR || CORE_CTL_RD || CLUSTER_CTL_RD)
    |-> (SR_CRM == SYSREG_CRM_INJ && SR_OP2 == SYSREG_OP2_CTL))
    else $error("control forward on wrong encoding");

  a_feat_decode: assert property (
    (CORE_FEAT_RD || CLUSTER_FEAT_RD)
    |-> (SR_CRM == SYSREG_CRM_INJ && SR_OP2 == SYSREG_OP2_FEAT))
    else $error("feature forward on wrong encoding");

  a_unmapped: assert property (
    (any_acc && !hit_inj && !hit_sel && !hit_stat && !hit_synd) |-> SR_UNDEF)
    else $error("unmapped access not undefined");

  a_ctl_write_ok: assert property (
    (SR_WR && hit_ctl && CUR_EL == 2'h3) |-> (CORE_CTL_WR || CLUSTER_CTL_WR))
    else $error("control write at el3 not forwarded");

  a_refused_zero: assert property (
    (any_acc && !granted) |=> (SR_RDATA == 32'h0000_0000))
    else $error("refused access returned data");

  a_el1_gate: assert property (
    (any_acc && hit_inj && at_el1 && !reach_el1) |-> SR_UNDEF)
    else $error("el1 reached gated window");

  a_el2_gate: assert property (
    (any_acc && hit_inj && at_el2 && !AUX_CONTROL_EL3[AUX_ENABLE_BIT]) |-> SR_UNDEF)
    else $error("el2 reached gated window");

  a_el3_no_trap: assert property (
    (any_acc && CUR_EL == 2'h3) |-> !(SR_TRAP_EL2 || SR_TRAP_EL3))
    else $error("trap raised at el3");

  a_el0_wr: assert property (
    (SR_WR && hit_ctl && at_el0) |-> SR_UNDEF)
    else $error("el0 control write not undefined");

  a_no_fwd_refused: assert property (
    (SR_UNDEF || SR_TRAP_EL2 || SR_TRAP_EL3)
    |-> !(CORE_CTL_WR || CLUSTER_CTL_WR || CORE_CTL_RD || CLUSTER_CTL_RD))
    else $error("refused access forwarded");

  a_el2_trap_scope: assert property (
    SR_TRAP_EL2 |-> (at_el1 && TRUST_WORLD_BIT && HYP_ERROR_REGISTER_TRAP))
    else $error("trap to el2 out of scope");

  a_el3_trap_scope: assert property (
    SR_TRAP_EL3 |-> ((at_el1 || at_el2) && MON_ERROR_REGISTER_TRAP))
    else $error("trap to el3 out of scope");

  a_one_outcome: assert property (
    $onehot0({SR_UNDEF, SR_TRAP_EL2, SR_TRAP_EL3}))
    else $error("more than one access outcome");

  a_feat_core: assert property (
    CORE_FEAT_RD |-> (!chooser_reg && SR_RD))
    else $error("core feature read with wrong chooser");

  a_feat_cluster: assert property (
    CLUSTER_FEAT_RD |-> (chooser_reg && SR_RD))
    else $error("cluster feature read with wrong chooser");

  a_feat_el0: assert property (
    (any_acc && hit_feat && at_el0) |-> SR_UNDEF)
    else $error("el0 feature access not undefined");

  a_feat_el3: assert property (
    (SR_RD && hit_feat && CUR_EL == 2'h3) |-> (CORE_FEAT_RD || CLUSTER_FEAT_RD))
    else $error("feature read at el3 not forwarded");

  a_stat_core: assert property (
    CORE_STAT_RD |-> (!chooser_reg && hit_stat))
    else $error("core status read with wrong chooser");

  a_stat_cluster: assert property (
    CLUSTER_STAT_RD |-> (chooser_reg && hit_stat))
    else $error("cluster status read with wrong chooser");

  a_na_el1: assert property (
    (any_acc && hit_stat && at_el1 && GENERAL_EXCEPTION_TRAP && TRUST_WORLD_BIT) |-> SR_UNDEF)
    else $error("el1 under host trap reached status");

  a_secure_el2: assert property (
    (any_acc && hit_stat && at_el2 && !TRUST_WORLD_BIT) |-> SR_UNDEF)
    else $error("secure el2 reached status");

  a_stat_el0: assert property (
    (any_acc && hit_stat && at_el0) |-> SR_UNDEF)
    else $error("el0 status access not undefined");

  a_synd_hold: assert property (
    (!EXC_TAKE_EL1 && !SR_WR) |=> $stable(EL1_SYNDROME))
    else $error("syndrome changed without cause");

  a_synd_write: assert property (
    (granted && SR_WR && hit_synd && !EXC_TAKE_EL1)
    |=> (EL1_SYNDROME[31:SYND_VALID_BIT] == $past(SR_WDATA[31:SYND_VALID_BIT])))
    else $error("syndrome write lost");

  a_synd_size: assert property (
    (EXC_TAKE_EL1 && EXC_INSN_32) |=> EL1_SYNDROME[SYND_SIZE_BIT])
    else $error("32-bit opcode size not recorded");

  a_size16: assert property (
    (EXC_TAKE_EL1 && !EXC_INSN_32 && !size_forced) |=> !EL1_SYNDROME[SYND_SIZE_BIT])
    else $error("16-bit opcode size not recorded");

  a_serror_size: assert property (
    (EXC_TAKE_EL1 && EXC_CLASS == EC_SERROR) |=> EL1_SYNDROME[SYND_SIZE_BIT])
    else $error("serror opcode size not forced");

  a_invalid_cap: assert property (
    (EXC_TAKE_EL1 && !EXC_SYND_VALID && EXC_CLASS != EC_SERROR)
    |=> !EL1_SYNDROME[SYND_VALID_BIT])
    else $error("invalid syndrome flagged valid");

  a_synd_valid: assert property (
    (EXC_TAKE_EL1 && EXC_SYND_VALID && EXC_CLASS != EC_SERROR)
    |=> (EL1_SYNDROME[23:0] == $past(EXC_SYND)))
    else $error("valid syndrome field not captured");

  a_synd_serror: assert property (
    (EXC_TAKE_EL1 && EXC_CLASS == EC_SERROR) |=> (EL1_SYNDROME[23:0] == $past(EXC_SERROR_SYND)))
    else $error("serror syndrome not captured");

  a_sel_high_zero: assert property (
    (SR_RD && granted && hit_sel) |=> (SR_RDATA[31:1] == 31'h0000_0000))
    else $error("chooser upper bits not zero");

  a_chooser_hold: assert property (
    !(SR_WR && hit_sel) |=> $stable(chooser_reg))
    else $error("chooser changed without write");

endmodule : ras_record_window_and_syndrome

// File: shared/ras_window_pkg.sv
package ras_window_pkg;

  // ==========================================================
  // system-register encodings
  // ==========================================================
  localparam logic [1:0] SYSREG_OP0       = 2'h3;
  localparam logic [2:0] SYSREG_OP1       = 3'h0;
  localparam logic [3:0] SYSREG_CRN       = 4'hF;
  localparam logic [3:0] SYSREG_CRM_INJ   = 4'h2;
  localparam logic [2:0] SYSREG_OP2_FEAT  = 3'h0;
  localparam logic [2:0] SYSREG_OP2_CTL   = 3'h1;
  // own choices for windows with no printed encoding
  localparam logic [3:0] SYSREG_CRM_OWN   = 4'h3;
  localparam logic [2:0] SYSREG_OP2_SEL   = 3'h1;
  localparam logic [2:0] SYSREG_OP2_STAT  = 3'h2;
  localparam logic [2:0] SYSREG_OP2_SYND  = 3'h3;

  // ==========================================================
  // field layouts
  // ==========================================================
  localparam int CHOOSER_BIT       = 0;
  localparam int AUX_ENABLE_BIT    = 5;
  localparam int SYND_CLASS_LSB    = 26;
  localparam int SYND_SIZE_BIT     = 25;
  localparam int SYND_VALID_BIT    = 24;
  localparam int SYND_FIELD_W      = 24;
  localparam int DATA_W            = 32;

  // ==========================================================
  // exception classes and reset values
  // ==========================================================
  localparam logic [5:0]  EC_UNKNOWN     = 6'h00;
  localparam logic [5:0]  EC_INSN_ABORT_L = 6'h20;
  localparam logic [5:0]  EC_INSN_ABORT_S = 6'h21;
  localparam logic [5:0]  EC_PC_ALIGN    = 6'h22;
  localparam logic [5:0]  EC_DATA_ABORT_L = 6'h24;
  localparam logic [5:0]  EC_DATA_ABORT_S = 6'h25;
  localparam logic [5:0]  EC_SP_ALIGN    = 6'h26;
  localparam logic [5:0]  EC_ILLEGAL     = 6'h0E;
  localparam logic [5:0]  EC_SERROR      = 6'h2F;
  localparam logic        CHOOSER_RESET  = 1'h0;
  localparam logic [31:0] SYND_RESET     = 32'h0000_0000;

  // ==========================================================
  // access outcome
  // ==========================================================
  typedef enum logic [1:0] {
    ACC_OK,
    ACC_UNDEF,
    ACC_TRAP_EL2,
    ACC_TRAP_EL3
  } access_outcome_t;

endpackage : ras_window_pkg

// File: verif/tb_ras_record_window_and_syndrome.sv
module tb_ras_record_window_and_syndrome;
  timeunit 1ns;
  timeprecision 1ps;
  import ras_window_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  // ==========================================================
  logic        clock = 1'b0, rst_b = 1'b0, sr_wr = 1'b0, sr_rd = 1'b0;
  logic [1:0]  op0 = SYSREG_OP0, cur_el = 2'h3;
  logic [2:0]  op1 = SYSREG_OP1, op2 = 3'h0;
  logic [3:0]  crn = SYSREG_CRN, crm = 4'h0;
  logic        ns = 1'b0, general_exception_trap = 1'b0, e2h = 1'b0, hyp = 1'b0, mon = 1'b0;
  logic [31:0] sr_wdata = 32'h0, aux2 = 32'h0, aux3 = 32'h0;
  logic [31:0] c_ctl = 32'h0, c_feat = 32'h0, c_stat = 32'h0;
  logic [31:0] k_ctl = 32'h0, k_feat = 32'h0, k_stat = 32'h0;
  logic        exc_take = 1'b0, exc_i32 = 1'b0, exc_valid = 1'b0;
  logic [5:0]  exc_class = 6'h00;
  logic [23:0] exc_synd = 24'h0, exc_serr = 24'h0;
  logic [31:0] sr_rdata, log_wdata, el1_synd;
  logic        sr_undef, trap2, trap3;
  logic        cc_wr, cc_rd, cf_rd, cs_rd, kc_wr, kc_rd, kf_rd, ks_rd;
  int          mismatches = 0, compares = 0;

  ras_record_window_and_syndrome ras_record_window_and_syndrome_i (
    .CLOCK(clock), .RST_B(rst_b), .SR_OP0(op0), .SR_OP1(op1), .SR_CRN(crn), .SR_CRM(crm),
    .SR_OP2(op2), .SR_WDATA(sr_wdata), .SR_WR(sr_wr), .SR_RD(sr_rd), .SR_RDATA(sr_rdata),
    .SR_UNDEF(sr_undef), .SR_TRAP_EL2(trap2), .SR_TRAP_EL3(trap3), .CUR_EL(cur_el),
    .TRUST_WORLD_BIT(ns), .GENERAL_EXCEPTION_TRAP(general_exception_trap), .HOST_EL2_MODE(e2h),
    .HYP_ERROR_REGISTER_TRAP(hyp), .MON_ERROR_REGISTER_TRAP(mon),
    .AUX_CONTROL_EL2(aux2), .AUX_CONTROL_EL3(aux3),
    .CORE_CTL_WR(cc_wr), .CORE_CTL_RD(cc_rd), .CORE_FEAT_RD(cf_rd), .CORE_STAT_RD(cs_rd),
    .CORE_CTL_RDATA(c_ctl), .CORE_FEAT_RDATA(c_feat), .CORE_STAT_RDATA(c_stat),
    .CLUSTER_CTL_WR(kc_wr), .CLUSTER_CTL_RD(kc_rd), .CLUSTER_FEAT_RD(kf_rd),
    .CLUSTER_STAT_RD(ks_rd), .CLUSTER_CTL_RDATA(k_ctl), .CLUSTER_FEAT_RDATA(k_feat),
    .CLUSTER_STAT_RDATA(k_stat), .LOG_WDATA(log_wdata), .EXC_TAKE_EL1(exc_take),
    .EXC_CLASS(exc_class), .EXC_INSN_32(exc_i32), .EXC_SYND_VALID(exc_valid),
    .EXC_SYND(exc_synd), .EXC_SERROR_SYND(exc_serr), .EL1_SYNDROME(el1_synd)
  );

  // ==========================================================
  // compare and access tasks
  // ==========================================================
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bits

  // flags are {undef, trap to EL2, trap to EL3}; pulses run core ctl wr down to cluster stat rd
  task automatic acc(input logic [3:0] m, input logic [2:0] o, input logic w, input logic r,
                     input logic [31:0] wd, input logic [2:0] fl, input logic [7:0] pl,
                     input logic [31:0] rd);
    @(posedge clock);
    crm <= m;
    op2 <= o;
    sr_wr <= w;
    sr_rd <= r;
    sr_wdata <= wd;
    #5;
    chk_bits({5'h00, sr_undef, trap2, trap3}, {5'h00, fl});
    chk_bits({cc_wr, cc_rd, cf_rd, cs_rd, kc_wr, kc_rd, kf_rd, ks_rd}, pl);
    if (w) chk_word(log_wdata, wd);
    @(posedge clock);
    sr_wr <= 1'b0;
    sr_rd <= 1'b0;
    #5;
    chk_word(sr_rdata, rd);
  endtask : acc

  // other aux bits are set to ones so that only the enable bit can matter
  task automatic ctx(input logic [1:0] el, input logic n, input logic t, input logic h,
                     input logic mo, input logic a2, input logic a3);
    @(posedge clock);
    cur_el <= el;
    ns <= n;
    general_exception_trap <= t;
    hyp <= h;
    mon <= mo;
    aux2 <= ~(32'h1 << AUX_ENABLE_BIT) | (32'(a2) << AUX_ENABLE_BIT);
    aux3 <= ~(32'h1 << AUX_ENABLE_BIT) | (32'(a3) << AUX_ENABLE_BIT);
  endtask : ctx

  task automatic logs(input logic [31:0] b);
    @(posedge clock);
    c_ctl <= b + 32'h1;
    c_feat <= b + 32'h2;
    c_stat <= b + 32'h3;
    k_ctl <= b + 32'h4;
    k_feat <= b + 32'h5;
    k_stat <= b + 32'h6;
  endtask : logs

  task automatic exc(input logic [5:0] c, input logic i, input logic v, input logic [23:0] s,
                     input logic [23:0] se, input logic [31:0] exp);
    @(posedge clock);
    exc_take <= 1'b1;
    exc_class <= c;
    exc_i32 <= i;
    exc_valid <= v;
    exc_synd <= s;
    exc_serr <= se;
    @(posedge clock);
    exc_take <= 1'b0;
    #5;
    chk_word(el1_synd, exp);
  endtask : exc

  task automatic stop_test;
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // clock, watchdog and tests
  // ==========================================================
  initial begin
    forever #12.5 clock = ~clock;
  end

  initial begin
    #200us;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    #5;
    chk_word(el1_synd, SYND_RESET);
    logs(32'hA000_0000);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h0, 8'h40, 32'hA000_0001);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 1, 0, 32'h5A5A_0F0F, 3'h0, 8'h80, 0);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_FEAT, 0, 1, 0, 3'h0, 8'h20, 32'hA000_0002);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_FEAT, 1, 0, 32'h1, 3'h4, 8'h00, 0);
    acc(SYSREG_CRM_OWN, SYSREG_OP2_STAT, 0, 1, 0, 3'h0, 8'h10, 32'hA000_0003);
    acc(SYSREG_CRM_INJ, 3'h7, 0, 1, 0, 3'h4, 8'h00, 0);
    acc(SYSREG_CRM_OWN, SYSREG_OP2_SEL, 1, 0, 32'hFFFF_FFFF, 3'h0, 8'h00, 0);
    acc(SYSREG_CRM_OWN, SYSREG_OP2_SEL, 0, 1, 0, 3'h0, 8'h00, 32'h1);
    logs(32'hB000_0000);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h0, 8'h04, 32'hB000_0004);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 1, 0, 32'hC3C3_3C3C, 3'h0, 8'h08, 0);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_FEAT, 0, 1, 0, 3'h0, 8'h02, 32'hB000_0005);
    acc(SYSREG_CRM_OWN, SYSREG_OP2_STAT, 0, 1, 0, 3'h0, 8'h01, 32'hB000_0006);
    crn <= 4'hE;
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h4, 8'h00, 0);
    crn <= SYSREG_CRN;
    ctx(2'h0, 1, 0, 0, 0, 1, 1);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h4, 8'h00, 0);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_FEAT, 0, 1, 0, 3'h4, 8'h00, 0);
    ctx(2'h1, 1, 0, 0, 0, 1, 0);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h4, 8'h00, 0);
    ctx(2'h1, 1, 0, 0, 0, 0, 1);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 1, 0, 32'h1, 3'h4, 8'h00, 0);
    ctx(2'h2, 1, 0, 0, 0, 0, 1);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h0, 8'h04, 32'hB000_0004);
    ctx(2'h1, 1, 0, 1, 0, 1, 1);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 1, 0, 32'h2, 3'h2, 8'h00, 0);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_FEAT, 0, 1, 0, 3'h2, 8'h00, 0);
    ctx(2'h1, 0, 0, 1, 0, 1, 1);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h0, 8'h04, 32'hB000_0004);
    ctx(2'h1, 1, 0, 1, 1, 1, 1);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h1, 8'h00, 0);
    ctx(2'h2, 1, 0, 0, 1, 1, 1);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_FEAT, 0, 1, 0, 3'h1, 8'h00, 0);
    ctx(2'h1, 1, 1, 0, 0, 1, 1);
    acc(SYSREG_CRM_OWN, SYSREG_OP2_STAT, 0, 1, 0, 3'h4, 8'h00, 0);
    ctx(2'h2, 0, 0, 0, 0, 1, 1);
    acc(SYSREG_CRM_OWN, SYSREG_OP2_STAT, 0, 1, 0, 3'h4, 8'h00, 0);
    acc(SYSREG_CRM_INJ, SYSREG_OP2_CTL, 0, 1, 0, 3'h4, 8'h00, 0);
    ctx(2'h3, 0, 0, 0, 0, 0, 0);
    exc(6'h15, 1, 1, 24'hABCDEF, 24'h0, {6'h15, 1'b1, 1'b1, 24'hABCDEF});
    exc(6'h15, 0, 1, 24'h00F00D, 24'h0, {6'h15, 1'b0, 1'b1, 24'h00F00D});
    exc(EC_DATA_ABORT_L, 0, 0, 24'h123456, 24'h0, {EC_DATA_ABORT_L, 2'b10, 24'h0});
    exc(EC_UNKNOWN, 0, 0, 24'h0, 24'h0, {EC_UNKNOWN, 2'b10, 24'h0});
    exc(EC_SERROR, 0, 0, 24'h111111, 24'h5A5A5A, {EC_SERROR, 2'b11, 24'h5A5A5A});
    acc(SYSREG_CRM_OWN, SYSREG_OP2_SYND, 1, 0, 32'h1234_5678, 3'h0, 8'h00, 0);
    acc(SYSREG_CRM_OWN, SYSREG_OP2_SYND, 0, 1, 0, 3'h0, 8'h00, 32'h1200_0000);
    stop_test();
  end
endmodule : tb_ras_record_window_and_syndrome
